// [ldm_dimming_ctrl.sv]
// Dimming mode control and soft-start sequencing for a six-channel LED sink driver
//
// Overview of operation
// R01: Mode select pin low selects direct PWM dimming.
// R02: PWM mode: sinks switch on and off following the PWM input.
// R03: Mode select floating or high selects mixed dimming.
// R04: Mixed mode output lags input by two periods: measure, then compute.
// R05: Mixed mode, duty 25% to 100%: sinks on, amplitude proportional to duty.
// R06: Mixed mode, duty below 25%: amplitude fixed at a quarter of full scale.
// R07: Low-duty mixed state: sink pulse duty is four times measured duty.
// R08: Amplitude DAC code has at least 512 steps.
// R09: Soft-start waits for supply valid, PWM present and enable together.
// R10: Soft-start lasts tens of milliseconds, longer in mixed than PWM mode.
// R11: PWM frequencies 100 Hz to 20 kHz are accepted; host keeps within.
// R12: Host should drive PWM between 100 Hz and 10 kHz.
// R13: After supply becomes valid, a delay of milliseconds precedes soft-start.
// R14: Duty measured by counting high time and period on the system clock.
`timescale 1ns/1ps
`default_nettype none
module ldm_dimming_ctrl
  import ldm_pkg::*;
#(
  parameter int UVLO_DELAY_CYC = LDM_UVLO_DELAY_CYC,
  parameter int SS_PWM_STEP_CYC = LDM_SS_PWM_STEP_CYC,
  parameter int SS_MIX_STEP_CYC = LDM_SS_MIX_STEP_CYC,
  parameter int PERIOD_MAX_CYC = LDM_PERIOD_MAX_CYC,
  parameter int PERIOD_MIN_CYC = LDM_PERIOD_MIN_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic enable_pin,
  input wire logic supply_input_ok,
  input wire logic mode_select_pin,
  input wire logic pwm_in,
  output logic [LDM_CH_COUNT-1:0] current_sink_channels,
  output logic [LDM_CODE_W-1:0] current_dac_code,
  output logic soft_start_active,
  output logic mixed_mode
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [LDM_CODE_W-1:0] ldm_min(input logic [LDM_CODE_W-1:0] a,
                                                     input logic [LDM_CODE_W-1:0] b);
    ldm_min = (a < b) ? a : b;
  endfunction : ldm_min

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic pwm_prev_q;
  logic pwm_s;
  logic mix_s;
  logic supply_s;
  logic en_s;
  logic pwm_rise;

  // Two flops on every pin input
  // Only the second stage is read, keeping metastability out of the logic
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
      pwm_prev_q <= 1'b0;
    end else begin
      meta_q <= {enable_pin, supply_input_ok, mode_select_pin, pwm_in};
      sync_q <= meta_q;
      pwm_prev_q <= sync_q[0];
    end
  end

  // Synchronised levels and PWM edge
  assign pwm_s = sync_q[0];
  assign mix_s = sync_q[1]; // [R01] [R03]
  assign supply_s = sync_q[2];
  assign en_s = sync_q[3];
  assign pwm_rise = pwm_s & ~pwm_prev_q;

  // ----------------------------------------------------------------
  // Period and high-time measurement
  // ----------------------------------------------------------------
  logic [LDM_CNT_W-1:0] per_cnt_q;
  logic [LDM_CNT_W-1:0] high_cnt_q;
  logic [LDM_CNT_W-1:0] high_pend_q;
  logic [LDM_CNT_W+1:0] burst_lim_q;
  logic [LDM_CNT_W-1:0] burst_cnt_q;
  logic [LDM_CODE_W-1:0] duty_pend_q;
  logic [LDM_CODE_W-1:0] duty_act_q;
  logic seen_edge_q;
  logic pend_valid_q;
  logic act_valid_q;
  logic per_ok;
  logic per_timeout;
  logic div_start;
  logic div_done;
  logic [LDM_CODE_W-1:0] div_quot;

  // Periods below the accepted range are not measured; longer ones use the capped count
  // A too-short period leaves the last good result in place
  assign per_ok = (per_cnt_q >= LDM_CNT_W'(PERIOD_MIN_CYC)); // [R11]
  assign per_timeout = (per_cnt_q == LDM_CNT_W'(PERIOD_MAX_CYC)); // [R11]
  assign div_start = pwm_rise & seen_edge_q & per_ok & en_s;

  // Counts high cycles and period cycles between rising edges
  always_ff @(posedge sys_clk) begin
    if (!resetn || !en_s) begin
      per_cnt_q <= '0;
      high_cnt_q <= '0;
      seen_edge_q <= 1'b0;
    end else if (pwm_rise) begin
      per_cnt_q <= LDM_CNT_W'(1); // [R14]
      high_cnt_q <= LDM_CNT_W'(1);
      seen_edge_q <= 1'b1;
    end else if (!per_timeout) begin
      per_cnt_q <= per_cnt_q + LDM_CNT_W'(1); // [R14]
      high_cnt_q <= high_cnt_q + LDM_CNT_W'(pwm_s); // [R14]
    end
  end

  // Ratio of high time to period, 512 counts full scale
  ldm_ratio_div u_div (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .start(div_start),
    .num(high_cnt_q),
    .den(per_cnt_q),
    .done(div_done),
    .quot(div_quot)
  );

  // Result of one period applies at the edge ending the next one
  // Holding one result back gives the two-period lag of mixed mode
  // A stalled input forces full or zero duty once the period runs out
  always_ff @(posedge sys_clk) begin
    if (!resetn || !en_s) begin
      duty_pend_q <= '0;
      duty_act_q <= '0;
      high_pend_q <= '0;
      burst_lim_q <= '0;
      pend_valid_q <= 1'b0;
      act_valid_q <= 1'b0;
    end else begin
      if (div_start) begin
        high_pend_q <= high_cnt_q;
      end
      if (div_done) begin
        duty_pend_q <= div_quot; // [R14]
        pend_valid_q <= 1'b1;
      end else if (pwm_rise && pend_valid_q) begin
        duty_act_q <= duty_pend_q; // [R04]
        burst_lim_q <= (LDM_CNT_W+2)'(high_pend_q) * (LDM_CNT_W+2)'(LDM_LOWDUTY_MULT); // [R07]
        act_valid_q <= 1'b1;
        pend_valid_q <= 1'b0;
      end else if (per_timeout) begin
        duty_act_q <= pwm_s ? LDM_DUTY_FULL : '0;
        burst_lim_q <= '0;
        act_valid_q <= 1'b1;
        pend_valid_q <= 1'b0;
      end
    end
  end

  // Burst timer restarted on every rising edge
  // Saturates so a missing edge cannot wrap the burst window
  always_ff @(posedge sys_clk) begin
    if (!resetn || pwm_rise) begin
      burst_cnt_q <= '0;
    end else if (burst_cnt_q != LDM_CNT_W'(PERIOD_MAX_CYC)) begin
      burst_cnt_q <= burst_cnt_q + LDM_CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Start-up sequencing
  // ----------------------------------------------------------------
  ldm_state_t state_q;
  ldm_state_t state_d;
  logic [LDM_CNT_W-1:0] delay_cnt_q;
  logic [LDM_CNT_W-1:0] step_cnt_q;
  logic [LDM_CODE_W-1:0] ramp_q;
  logic [LDM_CNT_W-1:0] step_lim;
  logic delay_done;
  logic step_done;
  logic start_ok;

  // Soft-start slope chosen by dimming mode
  assign step_lim = mix_s ? LDM_CNT_W'(SS_MIX_STEP_CYC - 1) : LDM_CNT_W'(SS_PWM_STEP_CYC - 1); // [R10]
  assign delay_done = (delay_cnt_q == LDM_CNT_W'(UVLO_DELAY_CYC - 1)); // [R13]
  assign step_done = (step_cnt_q >= step_lim);
  assign start_ok = supply_s & en_s & seen_edge_q; // [R09]

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      LDM_ST_OFF: begin
        if (supply_s) begin
          state_d = LDM_ST_DELAY;
        end
      end
      LDM_ST_DELAY: begin
        if (!supply_s) begin
          state_d = LDM_ST_OFF;
        end else if (delay_done) begin
          state_d = LDM_ST_WAIT; // [R13]
        end
      end
      LDM_ST_WAIT: begin
        if (!supply_s) begin
          state_d = LDM_ST_OFF;
        end else if (start_ok) begin
          state_d = LDM_ST_SOFT; // [R09]
        end
      end
      LDM_ST_SOFT, LDM_ST_RUN: begin
        if (!supply_s) begin
          state_d = LDM_ST_OFF;
        end else if (!en_s) begin
          state_d = LDM_ST_WAIT;
        end else if (state_q == LDM_ST_SOFT && ramp_q == LDM_DUTY_FULL) begin
          state_d = LDM_ST_RUN; // [R10]
        end
      end
      default: begin
        state_d = LDM_ST_OFF;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_q <= LDM_ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Start-up delay counter
  always_ff @(posedge sys_clk) begin
    if (!resetn || state_q != LDM_ST_DELAY) begin
      delay_cnt_q <= '0;
    end else if (!delay_done) begin
      delay_cnt_q <= delay_cnt_q + LDM_CNT_W'(1); // [R13]
    end
  end

  // Amplitude ramp, one code step per step interval
  // Restarts from zero whenever drive stops, so every start is soft
  always_ff @(posedge sys_clk) begin
    if (!resetn || (state_q != LDM_ST_SOFT && state_q != LDM_ST_RUN)) begin
      step_cnt_q <= '0;
      ramp_q <= '0;
    end else if (state_q == LDM_ST_SOFT && ramp_q != LDM_DUTY_FULL) begin
      step_cnt_q <= step_done ? '0 : step_cnt_q + LDM_CNT_W'(1);
      if (step_done) begin
        ramp_q <= ramp_q + LDM_CODE_W'(1); // [R10]
      end
    end
  end

  // ----------------------------------------------------------------
  // Output selection
  // ----------------------------------------------------------------
  logic low_duty;
  logic burst_on;
  logic mix_sink_on;
  logic sink_on;
  logic drive_on;
  logic [LDM_CODE_W-1:0] mix_target;
  logic [LDM_CODE_W-1:0] target;
  logic [LDM_CH_COUNT-1:0] sinks_q;
  logic [LDM_CODE_W-1:0] dac_q;

  // Mixed mode: DC amplitude above a quarter, quarter-scale bursts below
  // Sinks stay off until a computed duty has been applied or the period runs out
  assign low_duty = (duty_act_q < LDM_DUTY_QUARTER); // [R05] [R06]
  assign burst_on = ({2'b00, burst_cnt_q} < burst_lim_q); // [R07]
  assign mix_target = low_duty ? LDM_DUTY_QUARTER : duty_act_q; // [R05] [R06] [R08]
  assign mix_sink_on = act_valid_q & (low_duty ? burst_on : 1'b1); // [R04] [R05]
  // PWM mode: full amplitude, sinks follow the input
  assign target = mix_s ? (act_valid_q ? mix_target : '0) : LDM_DUTY_FULL;
  assign sink_on = mix_s ? mix_sink_on : pwm_s; // [R02]
  assign drive_on = (state_q == LDM_ST_SOFT) || (state_q == LDM_ST_RUN);

  // Registered sink gates and amplitude code
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sinks_q <= '0;
      dac_q <= '0;
    end else begin
      sinks_q <= {LDM_CH_COUNT{drive_on & sink_on}}; // [R02]
      dac_q <= drive_on ? ldm_min(target, ramp_q) : '0; // [R08] [R10]
    end
  end

  assign current_sink_channels = sinks_q;
  assign current_dac_code = dac_q;
  assign soft_start_active = (state_q == LDM_ST_SOFT);
  assign mixed_mode = mix_s;
endmodule : ldm_dimming_ctrl
`default_nettype wire

// [ldm_pkg.sv]
// Package of constants and the ratio divider used by the dimming control
package ldm_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int LDM_CLK_HZ = 20000000;
  localparam int LDM_UVLO_DELAY_US = 4000;
  localparam int LDM_UVLO_DELAY_CYC = (LDM_CLK_HZ / 1000000) * LDM_UVLO_DELAY_US;
  localparam int LDM_SS_PWM_MS = 20;
  localparam int LDM_SS_MIX_MS = 40;
  localparam int LDM_PWM_MIN_HZ = 100;
  localparam int LDM_PWM_MAX_HZ = 20000;
  localparam int LDM_PERIOD_MAX_CYC = LDM_CLK_HZ / LDM_PWM_MIN_HZ;
  localparam int LDM_PERIOD_MIN_CYC = LDM_CLK_HZ / LDM_PWM_MAX_HZ;
  localparam int LDM_CNT_W = 18;
  // ----------------------------------------------------------------
  // Amplitude scale
  // ----------------------------------------------------------------
  localparam int LDM_DUTY_BITS = 9;
  localparam int LDM_CODE_W = LDM_DUTY_BITS + 1;
  localparam logic [LDM_CODE_W-1:0] LDM_DUTY_FULL = 10'h200;
  localparam logic [LDM_CODE_W-1:0] LDM_DUTY_QUARTER = 10'h080;
  localparam int LDM_LOWDUTY_MULT = 4;
  localparam int LDM_SS_PWM_STEP_CYC = (LDM_CLK_HZ / 1000) * LDM_SS_PWM_MS / 512;
  localparam int LDM_SS_MIX_STEP_CYC = (LDM_CLK_HZ / 1000) * LDM_SS_MIX_MS / 512;
  localparam int LDM_CH_COUNT = 6;
  // ----------------------------------------------------------------
  // Control states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LDM_ST_OFF = 3'b000,
    LDM_ST_DELAY = 3'b001,
    LDM_ST_WAIT = 3'b010,
    LDM_ST_SOFT = 3'b011,
    LDM_ST_RUN = 3'b100
  } ldm_state_t;
endpackage : ldm_pkg

`timescale 1ns/1ps
`default_nettype none
// Restoring divider: quot = num * 512 / den, num <= den
module ldm_ratio_div
  import ldm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [LDM_CNT_W-1:0] num,
  input wire logic [LDM_CNT_W-1:0] den,
  output logic done,
  output logic [LDM_CODE_W-1:0] quot
);
  logic [LDM_CNT_W:0] rem_q;
  logic [LDM_CNT_W-1:0] den_q;
  logic [LDM_CODE_W-1:0] quot_q;
  logic [3:0] step_q;
  logic busy_q;
  logic done_q;
  logic ge;
  logic [LDM_CNT_W:0] rem_sub;

  // Compare and subtract for one quotient bit
  assign ge = rem_q >= {1'b0, den_q};
  assign rem_sub = ge ? rem_q - {1'b0, den_q} : rem_q;
  assign done = done_q;
  assign quot = quot_q;

  // One quotient bit per cycle, integer bit first
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rem_q <= '0;
      den_q <= '0;
      quot_q <= '0;
      step_q <= 4'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        rem_q <= {1'b0, num};
        den_q <= den;
        quot_q <= '0;
        step_q <= 4'h0;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        quot_q <= {quot_q[LDM_CODE_W-2:0], ge};
        rem_q <= {rem_sub[LDM_CNT_W-1:0], 1'b0};
        step_q <= step_q + 4'h1;
        if (step_q == 4'(LDM_CODE_W - 1)) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule : ldm_ratio_div
`default_nettype wire

// [ldm_pkg_note_unused.sv]
// Intentionally empty
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [ldm_dimming_ctrl_assertions.sv]
// Checker of the dimming control port behaviour
`timescale 1ns/1ps
`default_nettype none
module ldm_chk
  import ldm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic enable_pin,
  input wire logic supply_input_ok,
  input wire logic mode_select_pin,
  input wire logic pwm_in,
  input wire logic [LDM_CH_COUNT-1:0] current_sink_channels,
  input wire logic [LDM_CODE_W-1:0] current_dac_code,
  input wire logic soft_start_active,
  input wire logic mixed_mode
);
  // ------
  // Clocking and sequences
  // ------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_powered;
    (enable_pin && supply_input_ok)[*6];
  endsequence
  sequence s_supply_back;
    (!supply_input_ok)[*4] ##1 supply_input_ok;
  endsequence
  // ------
  // Properties
  // ------
  a_mode_pwm_low: assert property ((!mode_select_pin)[*4] |-> !mixed_mode)
    else $error("mixed flag high with mode pin low");
  a_mode_mix_high: assert property ((resetn && mode_select_pin)[*5] |-> mixed_mode)
    else $error("mixed flag low with mode pin high");
  a_sinks_all_equal: assert property (current_sink_channels == '0 || current_sink_channels == '1)
    else $error("sink channels differ");
  a_pwm_sink_follow: assert property ((!mixed_mode && soft_start_active)[*5] |->
    current_sink_channels[0] == $past(pwm_in, 3))
    else $error("sinks do not follow pwm");
  a_dac_full_scale: assert property (current_dac_code <= LDM_DUTY_FULL)
    else $error("dac code above full scale");
  a_start_gate_ok: assert property ($rose(soft_start_active) |->
    $past(supply_input_ok, 3) && $past(enable_pin, 3))
    else $error("soft start without supply and enable");
  a_supply_low_off: assert property ((!supply_input_ok)[*5] |->
    !soft_start_active && current_sink_channels == '0)
    else $error("outputs active with supply low");
  a_uvlo_wait_hold: assert property (s_supply_back |-> (!soft_start_active)[*8])
    else $error("soft start too soon after supply return");
  a_ramp_single_step: assert property (!mixed_mode && soft_start_active && $past(soft_start_active) |->
    current_dac_code == $past(current_dac_code) || current_dac_code == $past(current_dac_code) + 1)
    else $error("ramp step not zero or one");
  a_low_duty_quarter: assert property (s_powered ##0 (mixed_mode && $fell(current_sink_channels[0])) |->
    current_dac_code <= LDM_DUTY_QUARTER)
    else $error("pulsed sinks above quarter amplitude");
endmodule : ldm_chk

bind ldm_dimming_ctrl ldm_chk u_chk (.sys_clk(sys_clk), .resetn(resetn), .enable_pin(enable_pin),
  .supply_input_ok(supply_input_ok), .mode_select_pin(mode_select_pin), .pwm_in(pwm_in),
  .current_sink_channels(current_sink_channels), .current_dac_code(current_dac_code),
  .soft_start_active(soft_start_active), .mixed_mode(mixed_mode));
`default_nettype wire

// [ldm_host_model.sv]
// Host model driving the brightness PWM input
`timescale 1ns/1ps
`default_nettype none
module ldm_host_model
  import ldm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic run,
  input wire logic [LDM_CNT_W-1:0] period_cyc,
  input wire logic [LDM_CNT_W-1:0] high_cyc,
  output logic pwm_in
);
  // ------
  // Period counter
  // ------
  logic [LDM_CNT_W-1:0] cnt_q;
  // Wraps at the period the bench keeps inside the band
  always_ff @(posedge sys_clk) begin
    if (!run || cnt_q >= period_cyc - 1'b1) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
  // High at the start of each period, low while idle
  assign pwm_in = run && (cnt_q < high_cyc);
endmodule : ldm_host_model
`default_nettype wire

// [ldm_dimming_ctrl_tb_top.sv]
// Testbench of the dimming mode control
`timescale 1ns/1ps
`default_nettype none
module ldm_dimming_ctrl_tb_top
  import ldm_pkg::*;
();
  localparam int SSP = 2;
  localparam int SSM = 4;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic enable_pin = 1'b0;
  logic supply_input_ok = 1'b0;
  logic mode_select_pin = 1'b0;
  logic run = 1'b0;
  logic [LDM_CNT_W-1:0] per = 18'h00028;
  logic [LDM_CNT_W-1:0] high_cyc = 18'h0000a;
  logic pwm_in;
  logic [LDM_CH_COUNT-1:0] sinks;
  logic [LDM_CODE_W-1:0] dac;
  logic ss_act;
  logic mix;
  int bad_count = 0;
  int tests_run = 0;
  int ss_tot = 0;
  int base;
  int c;
  int p;
  int hh;
  integer seed = 2;
  // ------
  // Clock, partner and design
  // ------
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (ss_act === 1'b1) ss_tot <= ss_tot + 1;
  ldm_host_model u_host (.sys_clk(sys_clk), .run(run), .period_cyc(per), .high_cyc(high_cyc), .pwm_in(pwm_in));
  ldm_dimming_ctrl #(.UVLO_DELAY_CYC(20), .SS_PWM_STEP_CYC(SSP), .SS_MIX_STEP_CYC(SSM),
    .PERIOD_MAX_CYC(5000), .PERIOD_MIN_CYC(10)) u_dut (.sys_clk(sys_clk), .resetn(resetn),
    .enable_pin(enable_pin), .supply_input_ok(supply_input_ok), .mode_select_pin(mode_select_pin),
    .pwm_in(pwm_in), .current_sink_channels(sinks), .current_dac_code(dac), .soft_start_active(ss_act),
    .mixed_mode(mix));
  // ------
  // Helpers
  // ------
  task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk_val
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : cyc
  task automatic wait_ss(input logic lvl);
    int k;
    k = 0;
    while (ss_act !== lvl && k < 8000) begin
      @(posedge sys_clk);
      k++;
    end
    chk_val("soft start level", lvl, ss_act);
  endtask : wait_ss
  task automatic count_high(input int k, output int n);
    n = 0;
    repeat (k) begin
      @(posedge sys_clk);
      if (sinks[0] === 1'b1) n++;
    end
  endtask : count_high
  function automatic logic in_range(input int v, input int e);
    return v >= e - 8 && v <= e + 8;
  endfunction : in_range
  function automatic int exp_code(input int h, input int pp);
    return (h * 512 / pp < 128) ? 128 : h * 512 / pp;
  endfunction : exp_code
  task automatic run_mix(input int pp, input int h);
    enable_pin <= 1'b0;
    run <= 1'b0;
    cyc(10);
    mode_select_pin <= 1'b1;
    per <= 18'(pp);
    high_cyc <= 18'(h);
    enable_pin <= 1'b1;
    cyc(30);
    chk_val("soft start without pwm", 0, ss_act);
    base = ss_tot;
    run <= 1'b1;
    cyc(2 * pp - 2);
    chk_val("sinks before second period", 0, sinks);
    cyc(12);
    chk_val("sinks after second period", 6'h3f, sinks);
    wait_ss(1'b0);
    chk_val("mixed ramp in range", 1, in_range(ss_tot - base, 512 * SSM));
    cyc(pp);
    chk_val("mixed flag", 1, mix);
    chk_val("dac code", exp_code(h, pp), dac);
    count_high(2 * pp, c);
    chk_val("sink high cycles", (4 * h >= pp) ? 2 * pp : 8 * h, c);
    $display("test mixed period %0d high %0d done", pp, h);
  endtask : run_mix
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  // ------
  // Watchdog and sequence
  // ------
  initial begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    $display("ERROR watchdog expected finish seen timeout");
    conclude();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    supply_input_ok <= 1'b1;
    high_cyc <= 18'(10 + {$random(seed)} % 20);
    enable_pin <= 1'b1;
    cyc(40);
    chk_val("soft start without pwm", 0, ss_act);
    run <= 1'b1;
    wait_ss(1'b1);
    base = ss_tot;
    chk_val("mixed flag", 0, mix);
    count_high(160, c);
    chk_val("sink high cycles", 4 * high_cyc, c);
    wait_ss(1'b0);
    chk_val("pwm ramp in range", 1, in_range(ss_tot - base, 512 * SSP));
    cyc(2);
    chk_val("pwm full scale", LDM_DUTY_FULL, dac);
    $display("test pwm mode done");
    for (int i = 0; i < 6; i++) begin
      p = (i < 2) ? 200 : 100 + {$random(seed)} % 200;
      hh = (i == 0) ? 50 : (i == 1) ? 49 : (i % 2) ? 2 + {$random(seed)} % (p / 4 - 2)
        : (p + 3) / 4 + {$random(seed)} % (p / 2);
      run_mix(p, hh);
    end
    // Input held high: no more rising edges, period runs out
    high_cyc <= per;
    cyc(5100);
    chk_val("held high dac", LDM_DUTY_FULL, dac);
    chk_val("held high sinks", 6'h3f, sinks);
    $display("test held input done");
    supply_input_ok <= 1'b0;
    cyc(8);
    chk_val("soft start with supply low", 0, ss_act);
    chk_val("sinks with supply low", 0, sinks);
    supply_input_ok <= 1'b1;
    cyc(15);
    chk_val("soft start in supply delay", 0, ss_act);
    wait_ss(1'b1);
    $display("test supply drop done");
    conclude();
  end
endmodule : ldm_dimming_ctrl_tb_top
`default_nettype wire
